// ==== sfap_pkg.sv ====
// Package for the serial flash array protection block: geometry, commands, timing
package sfap_pkg;
  localparam int ADDR_W     = 25;
  localparam int SECT_W     = 9;
  localparam int NUM_SECT   = 512;
  localparam int SECT_LSB   = 16;
  localparam int SUB_LSB    = 12;
  localparam int PAGE_LSB   = 8;
  localparam int OTP_BYTES  = 64;
  localparam int OTP_AW     = 6;
  localparam int BP_W       = 4;
  localparam logic [3:0] BP_ALL_MIN = 4'ha;
  localparam logic [3:0] BP_NONE    = 4'h0;
  localparam logic [2:0] BYTE_BITS  = 3'h0;
  // Supply settle hold-off after power-on reset
  localparam int POR_DELAY_NS  = 1000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int POR_CYCLES    = (POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_CNT_W     = 8;

  typedef enum logic [3:0] {
    SFAP_CMD_NONE,
    SFAP_CMD_WREN,
    SFAP_CMD_WRDI,
    SFAP_CMD_PAGE_PROG,
    SFAP_CMD_SUB_ERASE,
    SFAP_CMD_SECT_ERASE,
    SFAP_CMD_BULK_ERASE,
    SFAP_CMD_OTP_PROG,
    SFAP_CMD_WR_LOCK,
    SFAP_CMD_WR_STATUS
  } sfap_cmd_t;

  typedef enum logic [1:0] {
    SFAP_OP_NONE,
    SFAP_OP_PROGRAM,
    SFAP_OP_ERASE,
    SFAP_OP_OTP
  } sfap_op_t;

  // Command as handed over at deselect
  typedef struct packed {
    logic              valid;
    sfap_cmd_t         cmd;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic [2:0]        bit_cnt;
    logic [1:0]        lock_val;
  } sfap_req_t;

  // Granted operation toward the array engine
  typedef struct packed {
    logic              go;
    sfap_op_t          op;
    logic [ADDR_W-1:0] base;
    logic [ADDR_W-1:0] last;
    logic [7:0]        and_mask;
  } sfap_grant_t;
endpackage

// ==== sfap_guard.sv ====
// Protection gate deciding which program and erase requests reach the flash array
`timescale 1ns/1ps

// Summary of operation
// - Programming only clears bits; data is ANDed with present, one page at most.
// - Erase accepted only for subsector, sector or whole array; never a page.
// - Erase sets every cell of the region to one.
// - Main array is 32 MB: 512 sectors of 64KB, 16 subsectors each.
// - Array has 131072 program pages of 256 bytes.
// - 64-byte one-time area lies outside main array addresses.
// - Sector n spans n*0x10000 to n*0x10000+0xFFFF.
// - Reset and internal timer hold off all modifying operations until supply valid.
// - Modifying commands run only if clock count is whole bytes.
// - Enable command sets modify latch; modifying commands refused while latch clear.
// - Sector with lock bit one rejects program and erase.
// - Lock-down bit one freezes that sector's lock until reset.
// - Lock update writes lock bits only where lock-down is clear.
// - After reset all sector lock bits are set before commands are accepted.
// - Top/bottom zero: value n 1..9 protects uppermost 2^(n-1) sectors.
// - Top/bottom one: value n 1..9 protects sectors 0 to 2^(n-1)-1.
// - Area decode uses four area-size bits and top/bottom bit from status.
// - Protect pin low locks the block-protect area and status against writes.
module sfap_guard
  import sfap_pkg::*;
(
  input  wire logic        core_clk,       // System clock, 100 MHz
  input  wire logic        sys_rst,        // Synchronous reset, active high
  input  wire sfap_req_t   req,            // Command captured at deselect
  input  wire logic        wp_pin_n,       // Write-protect pin, low protects
  output sfap_grant_t      grant,          // Granted array operation, one-cycle go
  output logic             discard,        // One-cycle pulse: modifying command refused
  output logic             modify_allowed, // Modify-allowed latch
  output logic             supply_ready,   // Power-on hold-off finished
  output logic [BP_W-1:0]  area_size,      // Block-protect bits
  output logic             area_from_low_end // Top/bottom bit
);

  typedef struct packed {
    logic [POR_CNT_W-1:0] por_cnt;
    logic                 ready;
    logic                 wel;
    logic [BP_W-1:0]      bp;
    logic                 tb;
    logic [NUM_SECT-1:0]  lock;
    logic [NUM_SECT-1:0]  lock_down;
    sfap_grant_t          grant;
    logic                 discard;
  } sfap_state_t;

  sfap_state_t st;
  sfap_state_t next_st;

  // Block-protect area test for one sector
  function automatic logic sfap_bp_hit(input logic [BP_W-1:0] bp, input logic tb,
                                       input logic [SECT_W-1:0] sect);
    logic [SECT_W:0] span;
    logic            hit;
    span = '0;
    hit  = 1'b0;
    if (bp == BP_NONE) begin
      hit = 1'b0;
    end else if (bp >= BP_ALL_MIN) begin
      hit = 1'b1;
    end else begin
      span = (SECT_W+1)'(1) << (bp - 4'h1);
      if (tb) begin
        hit = {1'b0, sect} < span;
      end else begin
        hit = {1'b0, sect} >= ((SECT_W+1)'(NUM_SECT) - span);
      end
    end
    return hit;
  endfunction

  // Sector index of a byte address
  function automatic logic [SECT_W-1:0] sfap_sect(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:SECT_LSB];
  endfunction

  logic [SECT_W-1:0] tgt_sect;
  logic              tgt_locked;
  logic              tgt_bp;
  logic              any_prot;
  logic              is_modify;
  logic              whole_bytes;

  assign tgt_sect    = sfap_sect(req.addr);
  assign tgt_locked  = st.lock[tgt_sect];
  assign tgt_bp      = sfap_bp_hit(st.bp, st.tb, tgt_sect);
  assign whole_bytes = (req.bit_cnt == BYTE_BITS);
  assign is_modify   = req.cmd inside {SFAP_CMD_PAGE_PROG, SFAP_CMD_SUB_ERASE,
                                       SFAP_CMD_SECT_ERASE, SFAP_CMD_BULK_ERASE,
                                       SFAP_CMD_OTP_PROG, SFAP_CMD_WR_LOCK,
                                       SFAP_CMD_WR_STATUS};

  always_comb begin
    any_prot = (st.bp != BP_NONE);
    for (int i = 0; i < NUM_SECT; i++) begin
      any_prot = any_prot | st.lock[i];
    end
  end

  always_comb begin
    next_st             = st;
    next_st.grant.go    = 1'b0;
    next_st.discard     = 1'b0;
    if (!st.ready) begin
      if (st.por_cnt == POR_CNT_W'(POR_CYCLES - 1)) begin
        next_st.ready = 1'b1;
      end else begin
        next_st.por_cnt = st.por_cnt + POR_CNT_W'(1);
      end
    end
    if (req.valid && st.ready) begin
      if (req.cmd == SFAP_CMD_WREN && whole_bytes) begin
        next_st.wel = 1'b1;
      end else if (req.cmd == SFAP_CMD_WRDI && whole_bytes) begin
        next_st.wel = 1'b0;
      end else if (is_modify) begin
        // Latch is consumed by every attempt, granted or not
        next_st.wel = 1'b0;
        if (!whole_bytes || !st.wel) begin
          next_st.discard = 1'b1;
        end else begin
          unique case (req.cmd)
            SFAP_CMD_PAGE_PROG: begin
              if (tgt_locked || tgt_bp) begin
                next_st.discard = 1'b1;
              end else begin
                next_st.grant.go       = 1'b1;
                next_st.grant.op       = SFAP_OP_PROGRAM;
                next_st.grant.base     = req.addr;
                next_st.grant.last     = {req.addr[ADDR_W-1:PAGE_LSB], {PAGE_LSB{1'b1}}};
                next_st.grant.and_mask = req.wdata;
              end
            end
            SFAP_CMD_OTP_PROG: begin
              next_st.grant.go       = 1'b1;
              next_st.grant.op       = SFAP_OP_OTP;
              next_st.grant.base     = ADDR_W'(req.addr[OTP_AW-1:0]);
              next_st.grant.last     = ADDR_W'(OTP_BYTES - 1);
              next_st.grant.and_mask = req.wdata;
            end
            SFAP_CMD_SUB_ERASE, SFAP_CMD_SECT_ERASE: begin
              if (tgt_locked || tgt_bp) begin
                next_st.discard = 1'b1;
              end else begin
                next_st.grant.go       = 1'b1;
                next_st.grant.op       = SFAP_OP_ERASE;
                next_st.grant.and_mask = 8'hff;
                if (req.cmd == SFAP_CMD_SUB_ERASE) begin
                  next_st.grant.base = {req.addr[ADDR_W-1:SUB_LSB], {SUB_LSB{1'b0}}};
                  next_st.grant.last = {req.addr[ADDR_W-1:SUB_LSB], {SUB_LSB{1'b1}}};
                end else begin
                  next_st.grant.base = {req.addr[ADDR_W-1:SECT_LSB], {SECT_LSB{1'b0}}};
                  next_st.grant.last = {req.addr[ADDR_W-1:SECT_LSB], {SECT_LSB{1'b1}}};
                end
              end
            end
            SFAP_CMD_BULK_ERASE: begin
              if (any_prot) begin
                next_st.discard = 1'b1;
              end else begin
                next_st.grant.go       = 1'b1;
                next_st.grant.op       = SFAP_OP_ERASE;
                next_st.grant.base     = '0;
                next_st.grant.last     = '1;
                next_st.grant.and_mask = 8'hff;
              end
            end
            SFAP_CMD_WR_LOCK: begin
              if (st.lock_down[tgt_sect]) begin
                next_st.discard = 1'b1;
              end else begin
                next_st.lock[tgt_sect]      = req.lock_val[0];
                next_st.lock_down[tgt_sect] = req.lock_val[1];
              end
            end
            SFAP_CMD_WR_STATUS: begin
              if (!wp_pin_n) begin
                next_st.discard = 1'b1;
              end else begin
                // status bits feed decode
                // Top bit sits above the top/bottom bit, so all four size bits are reachable
                next_st.bp = {req.wdata[6], req.wdata[4:2]};
                next_st.tb = req.wdata[5];
              end
            end
            default: begin
              next_st.discard = 1'b1;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st.por_cnt   <= '0;
      st.ready     <= 1'b0;
      st.wel       <= 1'b0;
      st.bp        <= '0;
      st.tb        <= 1'b0;
      st.lock      <= '1;
      st.lock_down <= '0;
      st.grant     <= '0;
      st.discard   <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign grant             = st.grant;
  assign discard           = st.discard;
  assign modify_allowed    = st.wel;
  assign supply_ready      = st.ready;
  assign area_size         = st.bp;
  assign area_from_low_end = st.tb;

  chk_upper_area_one: assert property (@(posedge core_clk) disable iff (sys_rst)
    (st.bp == 4'h1 && !st.tb) |-> sfap_bp_hit(st.bp, st.tb, 9'h01ff)
      && !sfap_bp_hit(st.bp, st.tb, 9'h01fe)) else $error("upper area of one wrong");
  chk_lower_area_nine: assert property (@(posedge core_clk) disable iff (sys_rst)
    (st.bp == 4'h9 && st.tb) |-> sfap_bp_hit(st.bp, st.tb, 9'h00ff)
      && !sfap_bp_hit(st.bp, st.tb, 9'h0100)) else $error("lower area of nine wrong");
  chk_por_holdoff: assert property (@(posedge core_clk) disable iff (sys_rst)
    !st.ready |=> !st.grant.go) else $error("grant during power-on hold-off");
  chk_latch_needed: assert property (@(posedge core_clk) disable iff (sys_rst)
    (req.valid && st.ready && is_modify && !st.wel) |=> !st.grant.go && st.discard)
    else $error("modify without latch not refused");
  chk_partial_byte: assert property (@(posedge core_clk) disable iff (sys_rst)
    (req.valid && st.ready && is_modify && !whole_bytes) |=> st.discard && !st.wel)
    else $error("partial byte command not discarded");
  chk_locked_reject: assert property (@(posedge core_clk) disable iff (sys_rst)
    (req.valid && st.ready && st.wel && tgt_locked
      && req.cmd inside {SFAP_CMD_PAGE_PROG, SFAP_CMD_SECT_ERASE})
    |=> !st.grant.go) else $error("locked sector granted");
  chk_lock_frozen: assert property (@(posedge core_clk) disable iff (sys_rst)
    st.lock_down[tgt_sect] |=> st.lock[$past(tgt_sect)] == $past(st.lock[tgt_sect]))
    else $error("frozen lock changed");
  chk_erase_ones: assert property (@(posedge core_clk) disable iff (sys_rst)
    (st.grant.go && st.grant.op == SFAP_OP_ERASE) |-> st.grant.and_mask == 8'hff
      && st.grant.base[SUB_LSB-1:0] == '0) else $error("erase not aligned to ones");
  chk_sect_span: assert property (@(posedge core_clk) disable iff (sys_rst)
    (req.valid && st.ready && st.wel && whole_bytes && req.cmd == SFAP_CMD_SECT_ERASE
      && !tgt_locked && !tgt_bp) |=> st.grant.go && st.grant.base[SECT_LSB-1:0] == '0
      && st.grant.last[SECT_LSB-1:0] == '1) else $error("sector erase span wrong");
  chk_prog_page: assert property (@(posedge core_clk) disable iff (sys_rst)
    (st.grant.go && st.grant.op == SFAP_OP_PROGRAM) |-> st.grant.last[PAGE_LSB-1:0] == '1
      && st.grant.last[ADDR_W-1:PAGE_LSB] == st.grant.base[ADDR_W-1:PAGE_LSB])
    else $error("program leaves its page");
  chk_otp_range: assert property (@(posedge core_clk) disable iff (sys_rst)
    (st.grant.go && st.grant.op == SFAP_OP_OTP) |-> st.grant.base < ADDR_W'(OTP_BYTES)
      && st.grant.last == ADDR_W'(OTP_BYTES - 1)) else $error("one-time range wrong");
  chk_bulk_clean: assert property (@(posedge core_clk) disable iff (sys_rst)
    (req.valid && st.ready && req.cmd == SFAP_CMD_BULK_ERASE && any_prot) |=> !st.grant.go)
    else $error("bulk erase granted over protection");
  chk_reset_locks: assert property (@(posedge core_clk)
    sys_rst |=> (&st.lock) && !st.ready && !st.wel) else $error("reset lock state wrong");
  chk_pin_status: assert property (@(posedge core_clk) disable iff (sys_rst)
    (req.valid && st.ready && req.cmd == SFAP_CMD_WR_STATUS && !wp_pin_n)
    |=> $stable(st.bp) && $stable(st.tb)) else $error("status changed with pin low");
  chk_lockdown_refuse: assert property (@(posedge core_clk) disable iff (sys_rst)
    (req.valid && st.ready && st.wel && whole_bytes && req.cmd == SFAP_CMD_WR_LOCK
      && st.lock_down[tgt_sect]) |=> st.discard) else $error("frozen lock write accepted");
  chk_ready_holds: assert property (@(posedge core_clk) disable iff (sys_rst)
    st.ready |=> st.ready) else $error("ready dropped without reset");
  chk_prog_mask: assert property (@(posedge core_clk) disable iff (sys_rst)
    (req.valid && st.ready && st.wel && whole_bytes && req.cmd == SFAP_CMD_PAGE_PROG
      && !tgt_locked && !tgt_bp) |=> st.grant.go && st.grant.and_mask == $past(req.wdata))
    else $error("program data not passed");
  chk_area_all: assert property (@(posedge core_clk) disable iff (sys_rst)
    (st.bp >= BP_ALL_MIN) |-> sfap_bp_hit(st.bp, st.tb, 9'h000)
      && sfap_bp_hit(st.bp, st.tb, 9'h1ff)) else $error("full area not covered");
  chk_lower_area_one: assert property (@(posedge core_clk) disable iff (sys_rst)
    (st.bp == 4'h1 && st.tb) |-> sfap_bp_hit(st.bp, st.tb, 9'h000)
      && !sfap_bp_hit(st.bp, st.tb, 9'h001)) else $error("lower area of one wrong");
  chk_latch_consumed: assert property (@(posedge core_clk) disable iff (sys_rst)
    (req.valid && st.ready && is_modify) |=> !st.wel && !(st.grant.go && st.discard))
    else $error("latch survived a modifying command");
endmodule

// ==== sfap_host.sv ====
// Host model: sends each command, preceded by the enable command unless told not to
`timescale 1ns/1ps
module sfap_host
  import sfap_pkg::*;
(
  input  wire logic      core_clk, // System clock
  input  wire logic      sys_rst,  // Synchronous reset
  input  wire logic      go,       // One-cycle start of a command
  input  wire logic      no_wren,  // Leave out the enable command
  input  wire sfap_req_t cmd_in,   // Command to send
  output sfap_req_t      req       // Request toward the gate
);
  sfap_req_t pend;

  always @(posedge core_clk) begin
    if (sys_rst) begin
      req <= '0;
      pend <= '0;
    end else if (go && !no_wren) begin
      req <= '{valid: 1'b1, cmd: SFAP_CMD_WREN, default: '0};
      pend <= cmd_in;
    end else if (go) begin
      req <= cmd_in;
    end else if (pend.valid) begin
      req <= pend;
      pend.valid <= 1'b0;
    end else begin
      // Idle fields toggle so stale values never look valid
      req <= {1'b0, ~req[$bits(req)-2:0]};
    end
  end
endmodule

// ==== tb_top.sv ====
// Self-checking testbench for the protection gate
`timescale 1ns/1ps
module tb_top
  import sfap_pkg::*;
;
  logic              core_clk = 0;
  logic              sys_rst = 1;
  logic              go = 0;
  logic              no_wren = 0;
  logic              wp_pin_n = 1;
  sfap_req_t         cmd_in = '0;
  sfap_req_t         req;
  sfap_grant_t       grant;
  logic              discard;
  logic              modify_allowed;
  logic              supply_ready;
  logic [BP_W-1:0]   area_size;
  logic              area_from_low_end;
  logic              g;
  logic              d;
  int                bad_count = 0;
  int                samples_checked = 0;
  logic [4:0]        pv[11] = '{1, 1, 2, 2, 17, 17, 25, 25, 9, 10, 0};
  logic [8:0]        ps[11] = '{511, 510, 510, 509, 0, 1, 255, 256, 256, 1, 511};
  logic              pe[11] = '{1, 0, 1, 0, 1, 0, 1, 0, 1, 1, 0};

  always #5 core_clk = ~core_clk;

  sfap_host i_sfap_host (.core_clk(core_clk), .sys_rst(sys_rst), .go(go), .no_wren(no_wren),
    .cmd_in(cmd_in), .req(req));
  sfap_guard i_sfap_guard (.core_clk(core_clk), .sys_rst(sys_rst), .req(req),
    .wp_pin_n(wp_pin_n), .grant(grant), .discard(discard), .modify_allowed(modify_allowed),
    .supply_ready(supply_ready), .area_size(area_size), .area_from_low_end(area_from_low_end));

  task check(string what, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Sends one command and compares the discard pulse with the expected one
  task send(sfap_cmd_t c, logic [24:0] a, logic [7:0] w, logic [2:0] b, logic [1:0] l,
            logic nw, logic ed);
    @(posedge core_clk);
    cmd_in <= '{valid: 1'b1, cmd: c, addr: a, wdata: w, bit_cnt: b, lock_val: l};
    no_wren <= nw;
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    g = 0;
    d = 0;
    repeat (5) begin
      @(posedge core_clk);
      #1;
      g |= grant.go;
      d |= discard;
    end
    check("discard", d, ed);
  endtask

  task erase(sfap_cmd_t c, logic [24:0] a, logic [24:0] lo, logic [24:0] hi);
    send(c, a, 8'h00, 3'h0, 2'h0, 0, 0);
    check("erase_go", g, 1);
    check("erase_op", grant.op, SFAP_OP_ERASE);
    check("erase_base", grant.base, lo);
    check("erase_last", grant.last, hi);
    check("erase_mask", grant.and_mask, 8'hff);
  endtask

  task tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    #200_000;
    bad_count++;
    tally_and_finish();
  end

  initial begin
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    send(SFAP_CMD_WR_LOCK, 25'h005_0000, 8'h00, 3'h0, 2'h0, 0, 0);
    check("early_ready", supply_ready, 0);
    check("early_latch", modify_allowed, 0);
    repeat (POR_CYCLES) @(posedge core_clk);
    #1 check("ready", supply_ready, 1);
    send(SFAP_CMD_PAGE_PROG, 25'h005_0123, 8'ha5, 3'h0, 2'h0, 0, 1);
    send(SFAP_CMD_WR_LOCK, 25'h005_0000, 8'h00, 3'h0, 2'h0, 0, 0);
    send(SFAP_CMD_PAGE_PROG, 25'h005_0123, 8'ha5, 3'h0, 2'h0, 1, 1);
    check("latch", modify_allowed, 0);
    send(SFAP_CMD_PAGE_PROG, 25'h005_0123, 8'ha5, 3'h3, 2'h0, 0, 1);
    send(SFAP_CMD_PAGE_PROG, 25'h005_0123, 8'ha5, 3'h0, 2'h0, 0, 0);
    check("prog_go", g, 1);
    check("prog_op", grant.op, SFAP_OP_PROGRAM);
    check("prog_last", grant.last, 25'h005_01ff);
    check("prog_mask", grant.and_mask, 8'ha5);
    erase(SFAP_CMD_SUB_ERASE, 25'h005_1234, 25'h005_1000, 25'h005_1fff);
    erase(SFAP_CMD_SECT_ERASE, 25'h005_1234, 25'h005_0000, 25'h005_ffff);
    send(SFAP_CMD_OTP_PROG, 25'h000_0005, 8'h3c, 3'h0, 2'h0, 0, 0);
    check("otp_op", grant.op, SFAP_OP_OTP);
    check("otp_last", grant.last, 25'h000_003f);
    send(SFAP_CMD_BULK_ERASE, 25'h000_0000, 8'h00, 3'h0, 2'h0, 0, 1);
    for (int s = 0; s < NUM_SECT; s++)
      send(SFAP_CMD_WR_LOCK, {s[8:0], 16'h0000}, 8'h00, 3'h0, 2'h0, 0, 0);
    erase(SFAP_CMD_BULK_ERASE, 25'h000_0000, 25'h000_0000, 25'h1ff_ffff);
    foreach (pv[i]) begin
      send(SFAP_CMD_WR_STATUS, 25'h000_0000,
           {1'b0, pv[i][3], pv[i][4], pv[i][2:0], 2'b00}, 3'h0, 2'h0, 0, 0);
      check("area_size", area_size, pv[i][3:0]);
      check("low_end", area_from_low_end, pv[i][4]);
      send(SFAP_CMD_PAGE_PROG, {ps[i], 16'h0010}, 8'h0f, 3'h0, 2'h0, 0, pe[i]);
      check("area_go", g, !pe[i]);
    end
    wp_pin_n <= 1'b0;
    send(SFAP_CMD_WR_STATUS, 25'h000_0000, 8'h04, 3'h0, 2'h0, 0, 1);
    check("wp_area", area_size, 0);
    wp_pin_n <= 1'b1;
    send(SFAP_CMD_WR_LOCK, 25'h005_0000, 8'h00, 3'h0, 2'h3, 0, 0);
    send(SFAP_CMD_WR_LOCK, 25'h005_0000, 8'h00, 3'h0, 2'h0, 0, 1);
    send(SFAP_CMD_SUB_ERASE, 25'h005_0000, 8'h00, 3'h0, 2'h0, 0, 1);
    tally_and_finish();
  end
endmodule
